// ### hdl/lane_map_pkg.sv
// Shared widths, mode codes and carrier structs for the lane sample mapper
package lane_map_pkg;
    localparam int NUM_CH     = 4;
    localparam int NUM_SMP    = 20;
    localparam int SMP_W      = 12;
    localparam int NUM_LANES  = 8;
    localparam int LANE_W     = 64;
    localparam int FIFO_DEPTH = 16;

    // Lane-mapping mode codes
    localparam logic [3:0] MODE_12B_6L_8B  = 4'h1;
    localparam logic [3:0] MODE_8B_4L_8B   = 4'h2;
    localparam logic [3:0] MODE_10B_4L_8B  = 4'h3;
    localparam logic [3:0] MODE_12B_3L_64B = 4'h4;
    localparam logic [3:0] MODE_8B_2L_64B  = 4'h5;
    localparam logic [3:0] MODE_12B_6L_64B = 4'h6;
    localparam logic [3:0] MODE_8B_4L_64B  = 4'h7;
    localparam logic [3:0] MODE_12B_4L_64B = 4'h8;
    localparam logic [3:0] MODE_8B_8L_8B   = 4'h9;
    localparam logic [3:0] MODE_10B_8L_8B  = 4'ha;
    localparam logic [3:0] MODE_12B_DUAL_8L = 4'hb;

    typedef logic [SMP_W-1:0] smp_t;

    // Samples right-aligned in 12 bits; s[channel][index]
    typedef struct packed {
        smp_t [NUM_CH-1:0][NUM_SMP-1:0] s;
    } smp_frame_s;

    // Lane octets left-aligned: octet 0 sits in bits 63:56
    typedef struct packed {
        logic [NUM_LANES-1:0]             lane_en;
        logic [3:0]                       octets;
        logic [NUM_LANES-1:0][LANE_W-1:0] lane;
    } lane_frame_s;

    typedef struct packed {
        logic        out_valid;
        lane_frame_s frame;
    } mapper_state_s;

    localparam int FRAME_W = $bits(smp_frame_s);
endpackage

// ### hdl/quad_adc_lane_sample_mapper.sv
// Sample FIFO and lane frame mapper for four converter channels
// Functional notes
// [R1] Mode 1: lanes 0-2 carry A0,A1,B0,B1 packed as 16-bit lane frames.
// [R2] Mode 1: lanes 3-5 repeat that packing with C for A, D for B.
// [R3] Mode 2: one octet per lane, lanes 0-3 carry A,B,C,D sample 0.
// [R4] Mode 3: lane n carries four 10-bit samples 0-3 of one channel.
// [R5] Mode 4: A0,B0,C0 packed over three 16-bit lane frames.
// [R6] Mode 5: lane 0 carries A0 then B0, lane 1 C0 then D0.
// [R7] Mode 6 uses the exact mode 1 lane packing.
// [R8] Mode 7: one octet per lane, like mode 2.
// [R9] Mode 8: lane n carries 12-bit samples 0 and 1 of one channel.
// [R10] Mode 9: channel lane pair, even lane sample 0, odd lane sample 1.
// [R11] Mode 10: even lane samples 0,2,4,6, odd lane samples 1,3,5,7.
// [R12] Mode 11: lane k carries channel k/4 samples k%4..k%4+16 step 4, then tail nibble.
// [R13] All tail bits left over in a frame are zero.
// [R14] Samples placed most significant bit first.
// [R15] Only the lowest-numbered lanes of a mode are enabled.
// [R16] Mode stays constant while the link runs; receiver uses same mode.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Fill side
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  wr_ready,
    // Drain side
    output logic                  rd_valid,
    output logic [WIDTH-1:0]      rd_data,
    input  wire logic             rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_state_s;

    fifo_state_s      st_q;
    fifo_state_s      st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign wr_ready = ce && (st_q.cnt != FULL_CNT);
    assign rd_valid = (st_q.cnt != '0);
    assign rd_data  = mem[st_q.rd];
    assign push     = wr_valid && wr_ready;
    assign pop      = ce && rd_valid && rd_ready;

    // Pointer wrap is explicit so any depth works, not only powers of two
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = (st_q.wr == LAST_PTR) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == LAST_PTR) ? '0 : st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Storage needs no reset; the count guards stale entries
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[st_q.wr] <= wr_data;
        end
    end
endmodule // sample_fifo

module quad_adc_lane_sample_mapper
    import lane_map_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Static configuration
    input  wire logic [3:0]               lane_map_mode,
    // Sample frames in
    input  wire logic                     in_valid,
    input  wire lane_map_pkg::smp_frame_s in_frame,
    output logic                          in_ready,
    // Lane frames out
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output lane_map_pkg::lane_frame_s     out_frame
);
    import lane_map_pkg::*;

    mapper_state_s st_q;
    mapper_state_s st_d;
    logic          fifo_valid;
    logic          fifo_ready;
    logic [FRAME_W-1:0] fifo_data;
    smp_frame_s    head;
    logic          load;
    smp_frame_s    src_q;
    logic [3:0]    mode_q;

    // Deep enough to ride out receiver stalls of a whole frame burst
    sample_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_valid (in_valid),
        .wr_data  (in_frame),
        .wr_ready (in_ready),
        .rd_valid (fifo_valid),
        .rd_data  (fifo_data),
        .rd_ready (fifo_ready)
    );

    assign head       = smp_frame_s'(fifo_data);
    assign fifo_ready = !st_q.out_valid || out_ready;
    assign load       = ce && fifo_valid && fifo_ready;
    assign out_valid  = st_q.out_valid;
    assign out_frame  = st_q.frame;

    // Builds every lane of one frame; unfilled bits stay zero
    function automatic lane_frame_s pack(input logic [3:0] m,
                                         input smp_frame_s f);
        lane_frame_s o;
        logic [47:0] g;
        o = '0; // R13
        g = '0;
        case (m)
            MODE_12B_6L_8B, MODE_12B_6L_64B: begin // R7
                for (int p = 0; p < 2; p++) begin // R2
                    g = {f.s[2*p][0], f.s[2*p][1],
                         f.s[2*p+1][0], f.s[2*p+1][1]}; // R1
                    for (int j = 0; j < 3; j++) begin
                        o.lane[3*p+j][LANE_W-1 -: 16] = g[47-16*j -: 16];
                    end
                end
                o.octets  = 4'h2;
                o.lane_en = 8'h3f; // R15
            end
            MODE_8B_4L_8B, MODE_8B_4L_64B: begin // R8
                for (int c = 0; c < NUM_CH; c++) begin // R3
                    o.lane[c][LANE_W-1 -: 8] = f.s[c][0][7:0];
                end
                o.octets  = 4'h1;
                o.lane_en = 8'h0f;
            end
            MODE_10B_4L_8B: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    for (int i = 0; i < 4; i++) begin // R4
                        o.lane[c][LANE_W-1-10*i -: 10] = f.s[c][i][9:0];
                    end
                end
                o.octets  = 4'h5;
                o.lane_en = 8'h0f;
            end
            MODE_12B_3L_64B: begin
                g = {f.s[0][0], f.s[1][0], f.s[2][0], 12'h000}; // R5
                for (int j = 0; j < 3; j++) begin
                    o.lane[j][LANE_W-1 -: 16] = g[47-16*j -: 16];
                end
                o.octets  = 4'h2;
                o.lane_en = 8'h07;
            end
            MODE_8B_2L_64B: begin
                o.lane[0][LANE_W-1 -: 16] = {f.s[0][0][7:0],
                                             f.s[1][0][7:0]}; // R6
                o.lane[1][LANE_W-1 -: 16] = {f.s[2][0][7:0],
                                             f.s[3][0][7:0]};
                o.octets  = 4'h2;
                o.lane_en = 8'h03;
            end
            MODE_12B_4L_64B: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    for (int i = 0; i < 2; i++) begin // R9
                        o.lane[c][LANE_W-1-12*i -: 12] = f.s[c][i];
                    end
                end
                o.octets  = 4'h3;
                o.lane_en = 8'h0f;
            end
            MODE_8B_8L_8B: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    for (int j = 0; j < 2; j++) begin // R10
                        o.lane[2*c+j][LANE_W-1 -: 8] = f.s[c][j][7:0];
                    end
                end
                o.octets  = 4'h1;
                o.lane_en = 8'hff;
            end
            MODE_10B_8L_8B: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    for (int j = 0; j < 2; j++) begin
                        for (int i = 0; i < 4; i++) begin // R11
                            o.lane[2*c+j][LANE_W-1-10*i -: 10] =
                                f.s[c][j+2*i][9:0];
                        end
                    end
                end
                o.octets  = 4'h5;
                o.lane_en = 8'hff;
            end
            MODE_12B_DUAL_8L: begin
                for (int k = 0; k < NUM_LANES; k++) begin
                    for (int i = 0; i < 5; i++) begin // R12
                        o.lane[k][LANE_W-1-12*i -: 12] =
                            f.s[k/4][k%4+4*i]; // R14
                    end
                end
                o.octets  = 4'h8;
                o.lane_en = 8'hff;
            end
            // Unsupported codes present an all-zero frame and enable no lane
            default: o = '0;
        endcase
        return o;
    endfunction

    // Mode is sampled per frame; changing it mid-link garbles the receiver
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.out_valid = 1'b1;
            st_d.frame     = pack(lane_map_mode, head); // R16
        end else if (out_ready) begin
            st_d.out_valid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Copy of the frame last loaded, read only by the checks below
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q  <= '0;
            mode_q <= 4'h0;
        end else if (load) begin
            src_q  <= head;
            mode_q <= lane_map_mode;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_load;
        load;
    endsequence

    sequence s_stall;
        ce && st_q.out_valid && !out_ready;
    endsequence

    // Mode recorded at the load edge, so no sampled-value call in a function
    function automatic logic mode_is(input logic [3:0] m);
        return out_valid && (mode_q == m);
    endfunction

    property p_load_shows;
        s_load |=> out_valid;
    endproperty
    a_load_shows: assert property (p_load_shows) // R16
        else $error("loaded frame not presented");

    property p_stall_holds;
        s_stall |=> $stable(out_frame) && out_valid;
    endproperty
    a_stall_holds: assert property (p_stall_holds) // R16
        else $error("frame changed while stalled");

    property p_mode1_lanes;
        s_load ##1 (out_valid && $past(lane_map_mode) == MODE_12B_6L_8B)
        |-> out_frame.lane[0][63:48] == {src_q.s[0][0], src_q.s[0][1][11:8]}
            && out_frame.lane[1][63:48] == {src_q.s[0][1][7:0],
                                            src_q.s[1][0][11:4]}
            && out_frame.lane[2][63:48] == {src_q.s[1][0][3:0],
                                            src_q.s[1][1]};
    endproperty
    a_mode1_lanes: assert property (p_mode1_lanes) // R1
        else $error("mode 1 lanes 0-2 wrong");

    property p_mode6_upper;
        s_load ##1 mode_is(MODE_12B_6L_64B)
        |-> out_frame.lane[3][63:48] == {src_q.s[2][0], src_q.s[2][1][11:8]}
            && out_frame.lane[5][63:48] == {src_q.s[3][0][3:0],
                                            src_q.s[3][1]};
    endproperty
    a_mode6_upper: assert property (p_mode6_upper) // R2
        else $error("mode 6 lanes 3-5 wrong");

    property p_mode2_octet;
        s_load ##1 mode_is(MODE_8B_4L_8B)
        |-> out_frame.lane[3][63:56] == src_q.s[3][0][7:0]
            && out_frame.octets == 4'h1 && out_frame.lane_en == 8'h0f;
    endproperty
    a_mode2_octet: assert property (p_mode2_octet) // R3
        else $error("mode 2 lane 3 wrong");

    property p_mode4_tail;
        s_load ##1 mode_is(MODE_12B_3L_64B)
        |-> out_frame.lane[2][63:48] == {src_q.s[2][0][3:0], 12'h000}
            && out_frame.lane_en == 8'h07;
    endproperty
    a_mode4_tail: assert property (p_mode4_tail) // R5
        else $error("mode 4 lane 2 wrong");

    property p_mode5_pair;
        s_load ##1 mode_is(MODE_8B_2L_64B)
        |-> out_frame.lane[1][63:48] == {src_q.s[2][0][7:0],
                                         src_q.s[3][0][7:0]};
    endproperty
    a_mode5_pair: assert property (p_mode5_pair) // R6
        else $error("mode 5 lane 1 wrong");

    property p_mode10_odd;
        s_load ##1 mode_is(MODE_10B_8L_8B)
        |-> out_frame.lane[7][63:54] == src_q.s[3][1][9:0]
            && out_frame.lane[7][33:24] == src_q.s[3][7][9:0];
    endproperty
    a_mode10_odd: assert property (p_mode10_odd) // R11
        else $error("mode 10 lane 7 wrong");

    property p_mode11_tail;
        s_load ##1 mode_is(MODE_12B_DUAL_8L)
        |-> out_frame.lane[5][3:0] == 4'h0
            && out_frame.lane[5][15:4] == src_q.s[1][17];
    endproperty
    a_mode11_tail: assert property (p_mode11_tail) // R12
        else $error("mode 11 lane 5 wrong");

    property p_unused_zero;
        out_valid |-> ((out_frame.lane_en[7] == 1'b0) ->
                       out_frame.lane[7] == '0)
                  && (out_frame.lane_en & (out_frame.lane_en + 8'h01)) == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // R15
        else $error("idle lane driven or lanes not lowest");
endmodule // quad_adc_lane_sample_mapper

`default_nettype wire

// ### test/lane_rx_model.sv
// Receiver model that takes lane frames from the mapper
`timescale 1ns/10ps
`default_nettype none

module lane_rx_model (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // Stall request and lane stream
    input  wire logic                      stall,
    input  wire logic                      out_valid,
    input  wire lane_map_pkg::lane_frame_s out_frame,
    output logic                           out_ready,
    // Last accepted frame
    output logic                           got,
    output lane_map_pkg::lane_frame_s      got_frame
);
    import lane_map_pkg::*;

    // Ready is registered, so a stall bites one edge late, like real logic
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
            got       <= 1'b0;
            got_frame <= '0;
        end else begin
            out_ready <= !stall;
            got       <= out_valid && out_ready && ce;
            // Whole frame kept; only the low lanes carry data
            if (out_valid && out_ready && ce) begin
                got_frame <= out_frame;
            end
        end
    end
endmodule // lane_rx_model

`default_nettype wire

// ### test/tb_quad_adc_lane_sample_mapper.sv
// Testbench for the lane sample mapper with FIFO
`timescale 1ns/10ps
`default_nettype none

module tb_quad_adc_lane_sample_mapper;
    import lane_map_pkg::*;
    localparam int FW = $bits(lane_frame_s);
    // Per mode: width, octets, lanes, samples, per channel, per lane,
    // lanes per channel, lane stride in bits
    localparam int T [13][8] = '{
        '{0, 0, 0, 0, 1, 1, 1, 0},      '{12, 2, 6, 8, 2, 2, 1, 24},
        '{8, 1, 4, 4, 1, 1, 1, 8},      '{10, 5, 4, 16, 4, 4, 1, 40},
        '{12, 2, 3, 3, 1, 1, 1, 12},    '{8, 2, 2, 4, 1, 1, 1, 8},
        '{12, 2, 6, 8, 2, 2, 1, 24},    '{8, 1, 4, 4, 1, 1, 1, 8},
        '{12, 3, 4, 8, 2, 2, 1, 24},    '{8, 1, 8, 8, 2, 1, 2, 8},
        '{10, 5, 8, 32, 8, 4, 2, 40},   '{12, 8, 8, 40, 20, 5, 4, 64},
        '{0, 0, 0, 0, 1, 1, 1, 0}};
    logic        ref_clk;
    logic        rst_n;
    logic        ce;
    logic        stall;
    logic [3:0]  lane_map_mode;
    logic        in_valid;
    smp_frame_s  in_frame;
    logic        in_ready;
    logic        out_valid;
    logic        out_ready;
    lane_frame_s out_frame;
    logic        got;
    lane_frame_s got_frame;
    int          bad_count;
    int          comparisons;

    quad_adc_lane_sample_mapper quad_adc_lane_sample_mapper_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .lane_map_mode(lane_map_mode), .in_valid(in_valid),
        .in_frame(in_frame), .in_ready(in_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_frame(out_frame));
    lane_rx_model lane_rx_model_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .stall(stall),
        .out_valid(out_valid), .out_frame(out_frame),
        .out_ready(out_ready), .got(got), .got_frame(got_frame));

    // Free-running 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Distinct sample per frame, channel and index; upper bits vary too
    function automatic smp_t smp(int sd, int ch, int ix);
        return smp_t'(sd * 499 + ch * 961 + ix * 167 + 2485);
    endfunction

    function automatic smp_frame_s mk(int sd);
        smp_frame_s f;
        for (int c = 0; c < NUM_CH; c++) begin
            for (int i = 0; i < NUM_SMP; i++) begin
                f.s[c][i] = smp(sd, c, i);
            end
        end
        return f;
    endfunction

    // Linear bit stream per mode, laid into lanes most significant first
    function automatic lane_frame_s exp_f(int m, int sd);
        lane_frame_s e;
        int          ch;
        int          ix;
        int          p;
        int          lw;
        smp_t        v;
        e = '0;
        lw = 8 * T[m][1];
        e.octets = 4'(T[m][1]);
        for (int l = 0; l < T[m][2]; l++) begin
            e.lane_en[l] = 1'b1;
        end
        for (int k = 0; k < T[m][3]; k++) begin
            ch = k / T[m][4];
            ix = (k / T[m][5]) % T[m][6] + T[m][6] * (k % T[m][5]);
            v = smp(sd, ch, ix);
            p = (k / T[m][5]) * T[m][7] + (k % T[m][5]) * T[m][0];
            for (int b = 0; b < T[m][0]; b++) begin
                e.lane[(p + b) / lw][63 - (p + b) % lw] = v[T[m][0] - 1 - b];
            end
        end
        return e;
    endfunction

    task automatic chk(string nm, logic [FW-1:0] seen, logic [FW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Offer a frame and hold it until taken; valid stays up afterwards
    task automatic send(smp_frame_s f);
        int i;
        in_valid <= 1'b1;
        in_frame <= f;
        for (i = 0; i < 50; i++) begin
            @(negedge ref_clk);
            if (in_ready === 1'b1) break;
        end
        if (i == 50) begin
            chk("in_ready wait", 0, 1);
            end_of_test();
        end
        @(posedge ref_clk);
    endtask

    task automatic recv(string nm, lane_frame_s e);
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge ref_clk);
            if (got === 1'b1) break;
        end
        if (i == 50) begin
            chk("out_valid wait", 0, 1);
            end_of_test();
        end
        chk(nm, got_frame, e);
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        @(negedge ref_clk);
        chk("out_valid", out_valid, 0);
        chk("out_frame", out_frame, 0);
        chk("in_ready", in_ready, 1);
        @(posedge ref_clk);
        $display("t_reset done");
    endtask

    // Mode codes 0 to 12: supported 1 to 11, unsupported 0 and 12 at both ends
    task automatic t_modes();
        for (int m = 0; m < 13; m++) begin
            lane_map_mode <= 4'(m);
            send(mk(m));
            in_valid <= 1'b0;
            recv($sformatf("mode %0d", m), exp_f(m, m));
        end
        $display("t_modes done");
    endtask

    // Frozen clock enable refuses input and launches nothing
    task automatic t_freeze();
        ce <= 1'b0;
        lane_map_mode <= 4'h2;
        in_valid <= 1'b1;
        in_frame <= mk(40);
        repeat (3) begin
            @(negedge ref_clk);
            chk("in_ready frozen", in_ready, 0);
            chk("out_valid frozen", out_valid, 0);
        end
        @(posedge ref_clk);
        ce <= 1'b1;
        send(mk(40));
        in_valid <= 1'b0;
        recv("after freeze", exp_f(2, 40));
        $display("t_freeze done");
    endtask

    // Stalled receiver: output register plus 16 FIFO words, then refusal
    task automatic t_fifo();
        int  i;
        logic r;
        stall <= 1'b1;
        lane_map_mode <= 4'h8;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 20; i++) begin
            in_valid <= 1'b1;
            in_frame <= mk(50 + i);
            @(negedge ref_clk);
            r = in_ready;
            @(posedge ref_clk);
            if (r !== 1'b1) break;
        end
        chk("frames taken", i, FIFO_DEPTH + 1);
        stall <= 1'b0;
        // Refused frame stays offered; it goes in as the first slot frees
        for (int k = 0; k <= FIFO_DEPTH + 1; k++) begin
            recv($sformatf("drain %0d", k), exp_f(8, 50 + k));
            in_valid <= 1'b0;
        end
        $display("t_fifo done");
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        stall = 1'b0;
        lane_map_mode = 4'h0;
        in_valid = 1'b0;
        in_frame = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_freeze();
        t_fifo();
        end_of_test();
    end
endmodule // tb_quad_adc_lane_sample_mapper

`default_nettype wire
